// ### verilog/tpss_pkg.sv
// Package with register map, field positions, reset values and shared types.
package tpss_pkg;

	localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GEN_STAT  = 8'h02;
	localparam logic [7:0] ADDR_IN_STAT   = 8'h03;

	localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
	localparam logic [7:0] RST_GEN_STAT  = 8'h00;
	localparam logic [7:0] RST_IN_STAT   = 8'h00;

	// Main control field positions.
	localparam int MC_GAIN_HI  = 7;
	localparam int MC_GAIN_LO  = 6;
	localparam int MC_STANDBY_REQUEST     = 5;
	localparam int MC_DEEPEST_LOW_POWER_REQUEST   = 4;
	localparam int MC_CGAIN_HI = 3;
	localparam int MC_CGAIN_LO = 2;
	localparam int MC_COMBO    = 1;
	localparam int MC_INT      = 0;

	// General status field positions.
	localparam int GS_BASE_COUNT_LIMIT_FLAG = 6;
	localparam int GS_CAL    = 5;
	localparam int GS_PWR    = 4;
	localparam int GS_BOOT   = 3;
	localparam int GS_MANY_TOUCH_BLOCK_FLAG   = 2;
	localparam int GS_PAT    = 1;
	localparam int GS_TOUCH  = 0;

	// Serial bus target address; the value is arbitrary.
	localparam logic [6:0] BUS_TARGET_ADDR = 7'h28;

	typedef enum logic [1:0] {
		TPSS_ACTIVE  = 2'b00,
		TPSS_STANDBY = 2'b01,
		TPSS_COMBO   = 2'b11,
		TPSS_DEEPEST_LOW_POWER_REQUEST  = 2'b10
	} tpss_pstate_t;

	typedef enum logic [2:0] {
		TPSS_B_IDLE = 3'b000,
		TPSS_B_ADDR = 3'b001,
		TPSS_B_AACK = 3'b011,
		TPSS_B_WR   = 3'b010,
		TPSS_B_WACK = 3'b110,
		TPSS_B_RD   = 3'b111,
		TPSS_B_RACK = 3'b101
	} tpss_bus_st_t;

	// Event and configuration inputs from the sensing engines.
	typedef struct packed {
		logic [7:0] touch;
		logic [7:0] active_en;
		logic [7:0] standby_en;
		logic [7:0] irq_en;
		logic       base_count_limit_flag;
		logic       analog_calibration_failure_flag;
		logic       power_button_held;
		logic       power_button_touched;
		logic       many_touch_block;
		logic       pattern_detect;
		logic       pattern_irq_enable;
	} tpss_sense_t;

	// Register access strobes from the serial bus engine.
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tpss_reg_wr_t;

endpackage

// ### verilog/tpss_serial_target.sv
// Serial management bus target engine with register pointer.
`timescale 1ns/1ps
module tpss_serial_target (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  sys_rst_in,
	// Bus pins
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_oe_n_out,
	// Register side
	input  wire logic [7:0]            rdata_in,
	output logic [7:0]                 rd_addr_out,
	output tpss_pkg::tpss_reg_wr_t     reg_wr_out
);
	import tpss_pkg::*;

	logic [2:0]   scl_s_q;
	logic [2:0]   sda_s_q;
	tpss_bus_st_t st_q;
	logic [7:0]   sh_q;
	logic [3:0]   cnt_q;
	logic         rw_q;
	logic         first_q;
	logic         ack_on_q;
	logic         got_ack_q;
	logic [7:0]   ptr_q;
	logic         drv_q;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_c;
	logic         stop_c;
	logic [7:0]   byte_c;

	assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
	assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
	assign start_c  = scl_s_q[1] & ~sda_s_q[1] & sda_s_q[2];
	assign stop_c   = scl_s_q[1] & sda_s_q[1] & ~sda_s_q[2];
	assign byte_c   = {sh_q[6:0], sda_s_q[1]};
	assign sda_oe_n_out = ~drv_q;
	assign rd_addr_out  = ptr_q;

	// Two flip-flops bring the pins in, the third keeps the last value.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_in};
			sda_s_q <= {sda_s_q[1:0], sda_in};
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q       <= TPSS_B_IDLE;
			sh_q       <= 8'h00;
			cnt_q      <= 4'h0;
			rw_q       <= 1'b0;
			first_q    <= 1'b0;
			ack_on_q   <= 1'b0;
			got_ack_q  <= 1'b0;
			ptr_q      <= 8'h00;
			drv_q      <= 1'b0;
			reg_wr_out <= '0;
		end else begin
			reg_wr_out.wr <= 1'b0;
			if (start_c) begin
				st_q    <= TPSS_B_ADDR;
				cnt_q   <= 4'h0;
				first_q <= 1'b1;
				drv_q   <= 1'b0;
			end else if (stop_c) begin
				st_q  <= TPSS_B_IDLE;
				drv_q <= 1'b0;
			end else if (scl_rise) begin
				case (st_q)
					TPSS_B_ADDR, TPSS_B_WR: begin
						sh_q  <= byte_c;
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h7) begin
							ack_on_q <= 1'b0;
							if (st_q == TPSS_B_ADDR) begin
								rw_q <= byte_c[0];
								st_q <= (byte_c[7:1] == BUS_TARGET_ADDR) ? TPSS_B_AACK
									: TPSS_B_IDLE;
							end else begin
								st_q <= TPSS_B_WACK;
								first_q <= 1'b0;
								if (first_q) begin
									ptr_q <= byte_c;
								end else begin
									reg_wr_out <= '{wr: 1'b1, addr: ptr_q, wdata: byte_c};
									ptr_q <= ptr_q + 8'h01;
								end
							end
						end
					end
					TPSS_B_RD: begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h7) begin
							st_q      <= TPSS_B_RACK;
							got_ack_q <= 1'b0;
						end
					end
					TPSS_B_RACK: begin
						if (sda_s_q[1]) begin
							st_q <= TPSS_B_IDLE;
						end else begin
							got_ack_q <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (st_q)
					TPSS_B_AACK, TPSS_B_WACK: begin
						if (!ack_on_q) begin
							drv_q    <= 1'b1;
							ack_on_q <= 1'b1;
						end else if (st_q == TPSS_B_AACK && rw_q) begin
							st_q  <= TPSS_B_RD;
							cnt_q <= 4'h0;
							sh_q  <= rdata_in;
							drv_q <= ~rdata_in[7];
							ptr_q <= ptr_q + 8'h01;
						end else begin
							st_q  <= TPSS_B_WR;
							cnt_q <= 4'h0;
							drv_q <= 1'b0;
						end
					end
					TPSS_B_RD: begin
						sh_q  <= {sh_q[6:0], 1'b0};
						drv_q <= ~sh_q[6];
					end
					TPSS_B_RACK: begin
						if (got_ack_q) begin
							st_q  <= TPSS_B_RD;
							cnt_q <= 4'h0;
							sh_q  <= rdata_in;
							drv_q <= ~rdata_in[7];
							ptr_q <= ptr_q + 8'h01;
						end else begin
							drv_q <= 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

endmodule

// ### verilog/tpss_top.sv
// Power state, gain selection and touch status register bank.
`timescale 1ns/1ps
module tpss_top (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 sys_rst_in,
	// Serial management bus pins
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe_n_out,
	// Sensing engine events and configuration
	input  wire tpss_pkg::tpss_sense_t sense_in,
	// Attention pin
	output logic                      alert_n_out,
	// Controls to the sensing engines
	output tpss_pkg::tpss_pstate_t    pstate_out,
	output logic [3:0]                active_gain_out,
	output logic [3:0]                standby_gain_out,
	output logic                      recal_out,
	output logic [7:0]                scan_mask_out
);
	import tpss_pkg::*;

	tpss_reg_wr_t rw;
	logic [7:0]   rd_addr;
	logic [7:0]   rdata;
	logic         drv_n;

	logic [7:0]   ctrl_q;
	logic [7:0]   ctrl_d;
	logic [7:0]   istat_q;
	logic [7:0]   istat_d;
	logic         pwr_q;
	logic         boot_q;
	logic         pat_q;
	logic         boot_pend_q;
	logic         sda_oe_n_q;

	tpss_pstate_t pstate_d;
	logic [3:0]   act_gain_d;
	logic [3:0]   standby_request_gain_d;
	logic [7:0]   mask_d;
	logic [7:0]   touch_eff;
	logic [7:0]   gstat;
	logic         int_clr;
	logic         int_set;
	logic         deepest_low_power_request;

	// Power state decode with deep sleep strongest.
	function automatic tpss_pstate_t pstate_f(input logic [7:0] c);
		if (c[MC_DEEPEST_LOW_POWER_REQUEST]) begin
			return TPSS_DEEPEST_LOW_POWER_REQUEST;
		end else if (c[MC_COMBO]) begin
			return TPSS_COMBO;
		end else if (c[MC_STANDBY_REQUEST]) begin
			return TPSS_STANDBY;
		end
		return TPSS_ACTIVE;
	endfunction

	// Gain code to multiplier.
	function automatic logic [3:0] gain_f(input logic [1:0] code);
		return 4'h1 << code;
	endfunction

	tpss_serial_target u_bus (
		.clk_in       (clk_in),
		.sys_rst_in   (sys_rst_in),
		.scl_in       (scl_in),
		.sda_in       (sda_in),
		.sda_oe_n_out (drv_n),
		.rdata_in     (rdata),
		.rd_addr_out  (rd_addr),
		.reg_wr_out   (rw)
	);

	assign pstate_d = pstate_f(ctrl_q);
	assign deepest_low_power_request   = (pstate_d == TPSS_DEEPEST_LOW_POWER_REQUEST);

	// Gain per input group.
	always_comb begin
		act_gain_d  = gain_f(ctrl_q[MC_GAIN_HI:MC_GAIN_LO]);
		standby_request_gain_d = act_gain_d;
		if (ctrl_q[MC_COMBO]) begin
			standby_request_gain_d = gain_f(ctrl_q[MC_CGAIN_HI:MC_CGAIN_LO]);
		end
	end

	// Scan selection per power state.
	always_comb begin
		case (pstate_d)
			TPSS_STANDBY: mask_d = sense_in.standby_en;
			TPSS_COMBO:   mask_d = sense_in.active_en | sense_in.standby_en;
			TPSS_DEEPEST_LOW_POWER_REQUEST:  mask_d = 8'h00;
			default:      mask_d = sense_in.active_en;
		endcase
	end

	// Inputs no longer scanned look released.
	assign touch_eff = sense_in.touch & mask_d;

	assign int_clr = rw.wr && (rw.addr == ADDR_MAIN_CTRL) && !rw.wdata[MC_INT];

	assign int_set = boot_pend_q
		| (sense_in.power_button_held & ~pwr_q)
		| (sense_in.pattern_detect & ~pat_q & sense_in.pattern_irq_enable)
		| (|(touch_eff & ~istat_q & sense_in.irq_en));

	// Main control register and interrupt flag; a new event beats a clear.
	always_comb begin
		ctrl_d = ctrl_q;
		if (rw.wr && rw.addr == ADDR_MAIN_CTRL) begin
			ctrl_d[7:1] = rw.wdata[7:1];
			ctrl_d[MC_INT] = ctrl_q[MC_INT] & rw.wdata[MC_INT];
		end
		if (int_set) begin
			ctrl_d[MC_INT] = 1'b1;
		end
		if (deepest_low_power_request) begin
			ctrl_d[MC_INT] = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_q <= RST_MAIN_CTRL;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Per-input touch flags.
	always_comb begin
		istat_d = touch_eff | (istat_q & ~{8{int_clr}});
		if (deepest_low_power_request) begin
			istat_d = 8'h00;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			istat_q <= RST_IN_STAT;
		end else begin
			istat_q <= istat_d;
		end
	end

	// Sticky general status flags.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pwr_q       <= RST_GEN_STAT[GS_PWR];
			boot_q      <= RST_GEN_STAT[GS_BOOT];
			pat_q       <= RST_GEN_STAT[GS_PAT];
			boot_pend_q <= 1'b1;
		end else begin
			boot_pend_q <= 1'b0;
			if (deepest_low_power_request) begin
				pwr_q  <= 1'b0;
				boot_q <= 1'b0;
				pat_q  <= 1'b0;
			end else begin
				pwr_q  <= sense_in.power_button_held
					| (pwr_q & ~(int_clr & ~sense_in.power_button_touched));
				boot_q <= boot_pend_q | (boot_q & ~int_clr);
				pat_q  <= sense_in.pattern_detect
					| (pat_q & ~int_clr);
			end
		end
	end

	// Live level flags and sticky event flags; the block flag stays out of the interrupt.
	always_comb begin
		gstat = 8'h00;
		if (!deepest_low_power_request) begin
			gstat[GS_BASE_COUNT_LIMIT_FLAG] = sense_in.base_count_limit_flag;
			gstat[GS_CAL]    = sense_in.analog_calibration_failure_flag;
			gstat[GS_MANY_TOUCH_BLOCK_FLAG]   = sense_in.many_touch_block;
		end
		gstat[GS_PWR]   = pwr_q;
		gstat[GS_BOOT]  = boot_q;
		gstat[GS_PAT]   = pat_q;
		gstat[GS_TOUCH] = |istat_q;
	end

	// Read data; writes to the status offsets reach nothing.
	always_comb begin
		if (rd_addr == ADDR_MAIN_CTRL) begin
			rdata = ctrl_q;
		end else if (rd_addr == ADDR_GEN_STAT) begin
			rdata = gstat;
		end else if (rd_addr == ADDR_IN_STAT) begin
			rdata = istat_q;
		end else begin
			rdata = 8'h00;
		end
	end

	// Registered outputs.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			alert_n_out      <= 1'b1;
			pstate_out       <= TPSS_ACTIVE;
			active_gain_out  <= 4'h1;
			standby_gain_out <= 4'h1;
			recal_out        <= 1'b0;
			scan_mask_out    <= 8'h00;
			sda_out          <= 1'b0;
			sda_oe_n_q       <= 1'b1;
		end else begin
			alert_n_out      <= ~ctrl_d[MC_INT];
			pstate_out       <= pstate_d;
			active_gain_out  <= act_gain_d;
			standby_gain_out <= standby_request_gain_d;
			recal_out        <= (act_gain_d != active_gain_out)
				| (standby_request_gain_d != standby_gain_out);
			scan_mask_out    <= mask_d;
			sda_out          <= 1'b0;
			sda_oe_n_q       <= drv_n;
		end
	end

	assign sda_oe_n_out = sda_oe_n_q;

endmodule

// ### testbench/tpss_top_sva.sv
// Checker for the power state, gain and status register bank ports.
`timescale 1ns/1ps
module tpss_top_sva (
	// Clock and reset
	input wire logic                  clk_in,
	input wire logic                  sys_rst_in,
	// Bus pins
	input wire logic                  scl_in,
	input wire logic                  sda_in,
	input wire logic                  sda_out,
	input wire logic                  sda_oe_n_out,
	// Sensing side
	input wire tpss_pkg::tpss_sense_t sense_in,
	input wire logic                  alert_n_out,
	input wire tpss_pkg::tpss_pstate_t pstate_out,
	input wire logic [3:0]            active_gain_out,
	input wire logic [3:0]            standby_gain_out,
	input wire logic                  recal_out,
	input wire logic [7:0]            scan_mask_out
);
	import tpss_pkg::*;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Any event other than the boot event that may legally raise the interrupt.
	wire logic cause = |(sense_in.touch & sense_in.irq_en) || sense_in.power_button_held
		|| (sense_in.pattern_detect && sense_in.pattern_irq_enable);
	a_reset_values: assert property (
		$fell(sys_rst_in) |-> alert_n_out && pstate_out == TPSS_ACTIVE && scan_mask_out == 8'h00
	) else $error("Outputs not at reset values after reset.");
	a_boot_alert: assert property (
		$fell(sys_rst_in) |-> ##[1:3] !alert_n_out
	) else $error("Attention not raised after reset.");
	a_gain_codes: assert property (
		active_gain_out inside {4'h1, 4'h2, 4'h4, 4'h8} && standby_gain_out inside {4'h1, 4'h2, 4'h4, 4'h8}
	) else $error("Gain output not a legal gain.");
	a_gain_share: assert property (
		pstate_out inside {TPSS_ACTIVE, TPSS_STANDBY} |-> standby_gain_out == active_gain_out
	) else $error("Standby gain differs outside combo.");
	a_recal_change: assert property (
		$changed(active_gain_out) || $changed(standby_gain_out) |-> ##[0:1] recal_out
	) else $error("Gain change without recalibration.");
	a_recal_pulse: assert property (
		recal_out |=> !recal_out
	) else $error("Recalibration pulse too long.");
	a_deepest_low_power_request_quiet: assert property (
		pstate_out == TPSS_DEEPEST_LOW_POWER_REQUEST [*2] |-> scan_mask_out == 8'h00 && alert_n_out
	) else $error("Deep sleep still scanning or alerting.");
	a_standby_scan: assert property (
		pstate_out == TPSS_STANDBY && $past(pstate_out) == TPSS_STANDBY
		|-> scan_mask_out == $past(sense_in.standby_en)
	) else $error("Standby scan mask wrong.");
	a_combo_scan: assert property (
		pstate_out == TPSS_COMBO && $past(pstate_out) == TPSS_COMBO
		|-> scan_mask_out == $past(sense_in.active_en | sense_in.standby_en)
	) else $error("Combo scan mask wrong.");
	a_alert_cause: assert property (
		$fell(alert_n_out) |-> $past(cause, 1) || $past(cause, 2) || $past(sys_rst_in, 2)
		|| $past(sys_rst_in, 3)
	) else $error("Attention raised without enabled cause.");
endmodule
bind tpss_top tpss_top_sva sva_u (.clk_in, .sys_rst_in, .scl_in, .sda_in, .sda_out,
	.sda_oe_n_out, .sense_in, .alert_n_out, .pstate_out, .active_gain_out,
	.standby_gain_out, .recal_out, .scan_mask_out);

// ### testbench/tpss_host_model.sv
// Host controller model that drives the serial management bus.
`timescale 1ns/1ps
module tpss_host_model (
	// Bus pins
	output logic      scl_out,
	output logic      sda_oe_n_out,
	input  wire logic sda_in
);
	localparam realtime Q = 31.25;
	initial begin
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
	end
	task automatic bus_start();
		sda_oe_n_out = 1'b1;
		#Q scl_out = 1'b1;
		#Q sda_oe_n_out = 1'b0;
		#Q scl_out = 1'b0;
		#Q;
	endtask
	task automatic bus_stop();
		sda_oe_n_out = 1'b0;
		#Q scl_out = 1'b1;
		#Q sda_oe_n_out = 1'b1;
		#Q;
	endtask
	// Sends eight bits and an acknowledge bit, sampling the line at each high phase.
	task automatic byte_io(input logic [7:0] tx, input logic ackv, output logic [7:0] rx,
		output logic ack);
		logic [8:0] v;
		logic [8:0] s;
		v = {tx, ackv};
		s = 9'h000;
		for (int i = 8; i >= 0; i--) begin
			sda_oe_n_out = v[i];
			#Q scl_out = 1'b1;
			#Q s = {s[7:0], sda_in};
			#Q scl_out = 1'b0;
			#Q;
		end
		rx = s[8:1];
		ack = s[0];
	endtask
endmodule

// ### testbench/tb.sv
// Testbench for the power state, gain and touch status register bank.
`timescale 1ns/1ps
module tb;
	import tpss_pkg::*;
	logic         clk_in;
	logic         sys_rst_in;
	logic         scl;
	logic         h_oe_n;
	logic         d_sda;
	logic         d_oe_n;
	wire          sda_w;
	tpss_sense_t  sense;
	logic         alert_n;
	tpss_pstate_t pstate;
	tpss_pstate_t ps;
	logic [3:0]   a_gain;
	logic [3:0]   s_gain;
	logic         recal;
	logic [7:0]   mask;
	int           num_errors = 0;
	int           n_compared = 0;
	int           n_recal = 0;
	// Open-drain line with pull-up.
	assign sda_w = h_oe_n & (d_oe_n | d_sda);
	tpss_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_w),
		.sda_out(d_sda), .sda_oe_n_out(d_oe_n), .sense_in(sense), .alert_n_out(alert_n),
		.pstate_out(pstate), .active_gain_out(a_gain), .standby_gain_out(s_gain),
		.recal_out(recal), .scan_mask_out(mask));
	tpss_host_model host_u (.scl_out(scl), .sda_oe_n_out(h_oe_n), .sda_in(sda_w));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) if (recal === 1'b1) n_recal++;
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string w);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL at %0t: %s got %h expected %h", $time, w, got, exp);
		end
	endtask
	task automatic chk_alert(input logic exp);
		check({7'h00, alert_n}, {7'h00, exp}, "attention pin");
	endtask
	task automatic settle();
		repeat (4) @(posedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       k;
		host_u.bus_start();
		host_u.byte_io({BUS_TARGET_ADDR, 1'b0}, 1'b1, r, k);
		check({7'h00, k}, 8'h00, "address ack");
		host_u.byte_io(a, 1'b1, r, k);
		host_u.byte_io(d, 1'b1, r, k);
		host_u.bus_stop();
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [7:0] e, input string w);
		logic [7:0] r;
		logic       k;
		host_u.bus_start();
		host_u.byte_io({BUS_TARGET_ADDR, 1'b0}, 1'b1, r, k);
		host_u.byte_io(a, 1'b1, r, k);
		host_u.bus_start();
		host_u.byte_io({BUS_TARGET_ADDR, 1'b1}, 1'b1, r, k);
		host_u.byte_io(8'hff, 1'b1, r, k);
		host_u.bus_stop();
		check(r, e, w);
	endtask
	task automatic finish_test();
		$display("Counts: %0d compared, %0d mismatched", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
	initial begin
		sys_rst_in = 1'b1;
		sense = '0;
		sense.active_en = 8'hf3;
		sense.standby_en = 8'h0c;
		sense.irq_en = 8'h0f;
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		settle();
		chk_alert(1'b0);
		expect_reg(ADDR_MAIN_CTRL, 8'h01, "control after boot");
		expect_reg(ADDR_GEN_STAT, 8'h08, "status after boot");
		expect_reg(ADDR_IN_STAT, RST_IN_STAT, "inputs after boot");
		wr(ADDR_MAIN_CTRL, 8'h00);
		chk_alert(1'b1);
		expect_reg(ADDR_GEN_STAT, 8'h00, "boot flag cleared");
		$display("Test boot done");
		@(posedge clk_in);
		sense.touch <= 8'h80;
		settle();
		chk_alert(1'b1);
		expect_reg(ADDR_IN_STAT, 8'h80, "input eight");
		expect_reg(ADDR_GEN_STAT, 8'h01, "summary touch");
		@(posedge clk_in);
		sense.touch <= 8'h01;
		settle();
		chk_alert(1'b0);
		@(posedge clk_in);
		sense.touch <= 8'h02;
		settle();
		expect_reg(ADDR_IN_STAT, 8'h83, "sticky inputs");
		wr(ADDR_MAIN_CTRL, 8'h00);
		chk_alert(1'b1);
		expect_reg(ADDR_IN_STAT, 8'h02, "held input stays");
		wr(ADDR_GEN_STAT, 8'hff);
		wr(ADDR_IN_STAT, 8'hff);
		expect_reg(ADDR_IN_STAT, 8'h02, "input status kept");
		expect_reg(ADDR_GEN_STAT, 8'h01, "general status kept");
		expect_reg(8'h05, 8'h00, "unmapped read");
		@(posedge clk_in);
		sense.touch <= 8'h00;
		$display("Test touch status done");
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_MAIN_CTRL, {g[1:0], 6'h00});
			settle();
			check({4'h0, a_gain}, 8'h01 << g, "gain");
			check({4'h0, s_gain}, 8'h01 << g, "shared gain");
		end
		check(n_recal[7:0], 8'h03, "recalibrations");
		wr(ADDR_MAIN_CTRL, 8'h4a);
		settle();
		check({4'h0, a_gain, s_gain}, 8'h24, "combo gains");
		check(mask, 8'hff, "combo scan");
		check(n_recal[7:0], 8'h04, "combo recalibration");
		$display("Test gain done");
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_MAIN_CTRL, {2'b00, i[0], i[2], 2'b00, i[1], 1'b0});
			settle();
			ps = i[2] ? TPSS_DEEPEST_LOW_POWER_REQUEST : i[1] ? TPSS_COMBO : i[0] ? TPSS_STANDBY : TPSS_ACTIVE;
			check({6'h00, pstate}, {6'h00, ps}, "power state");
		end
		check(mask, 8'h00, "deep sleep scan");
		wr(ADDR_MAIN_CTRL, 8'h20);
		settle();
		check(mask, 8'h0c, "standby scan");
		$display("Test power state done");
		wr(ADDR_MAIN_CTRL, 8'h00);
		@(posedge clk_in);
		sense.touch <= 8'h01;
		settle();
		chk_alert(1'b0);
		wr(ADDR_MAIN_CTRL, 8'h10);
		chk_alert(1'b1);
		expect_reg(ADDR_MAIN_CTRL, 8'h10, "deep sleep interrupt");
		expect_reg(ADDR_IN_STAT, 8'h00, "deep sleep inputs");
		@(posedge clk_in);
		sense.touch <= 8'h00;
		wr(ADDR_MAIN_CTRL, 8'h00);
		$display("Test deep sleep done");
		@(posedge clk_in);
		sense.pattern_detect <= 1'b1;
		sense.many_touch_block <= 1'b1;
		sense.base_count_limit_flag <= 1'b1;
		sense.analog_calibration_failure_flag <= 1'b1;
		settle();
		chk_alert(1'b1);
		expect_reg(ADDR_GEN_STAT, 8'h66, "event flags");
		@(posedge clk_in);
		sense.power_button_held <= 1'b1;
		sense.power_button_touched <= 1'b1;
		settle();
		chk_alert(1'b0);
		expect_reg(ADDR_GEN_STAT, 8'h76, "button flag");
		@(posedge clk_in);
		sense.power_button_held <= 1'b0;
		sense.pattern_detect <= 1'b0;
		wr(ADDR_MAIN_CTRL, 8'h00);
		chk_alert(1'b1);
		expect_reg(ADDR_GEN_STAT, 8'h74, "button still touched");
		@(posedge clk_in);
		sense.power_button_touched <= 1'b0;
		wr(ADDR_MAIN_CTRL, 8'h00);
		expect_reg(ADDR_GEN_STAT, 8'h64, "button released");
		@(posedge clk_in);
		sense.pattern_irq_enable <= 1'b1;
		sense.pattern_detect <= 1'b1;
		settle();
		chk_alert(1'b0);
		expect_reg(ADDR_GEN_STAT, 8'h66, "pattern interrupt");
		$display("Test event flags done");
		finish_test();
	end
endmodule
